// ### design/isa_bridge_consts.svh
`ifndef ISA_BRIDGE_CONSTS_SVH
`define ISA_BRIDGE_CONSTS_SVH
`define OFF_APIC_RELOC   8'h80
`define OFF_LAT_CTRL     8'h82
`define OFF_DMA_TYPE     8'h90
`define OFF_DDMA_LO      8'h92
`define OFF_DDMA_HI      8'h94
`define OFF_GEN_CFG      8'hB0
`define APIC_RELOC_MASK  8'h7F
`define LAT_CTRL_MASK    8'h09
`define DMA_TYPE_MASK    16'hFCFF
`define DDMA_BP_MASK     16'hFFC0
`define GEN_CFG_MASK     32'hFBFFDF72
`define APIC_TOP         16'hFEC0
`define PNP_ADDR_A       16'h0279
`define PNP_ADDR_B       16'h0A79
`define DISCARD_CYCLES   32'h0000_8000
`define RETRY_LIMIT      5'h10
`define LAT_DT_EN_BIT    0
`define LAT_SERR_BIT     3
`define GEN_SPLIT_BIT    4
`define GEN_ALT_BIT      5
`define GEN_PNP_BIT      6
`define GEN_PRI_TRI_BIT  11
`define GEN_SEC_TRI_BIT  12
`define GEN_IRQ8_BIT     14
`define GEN_SIRQ_BIT     16
`define GEN_STRAP_BIT    3
`define GEN_DECODE_BIT   1
`define PASSIVE_BIT      7
`endif

// ### design/isa_bridge_pkg.sv
package isa_bridge_pkg;
    typedef enum logic [1:0] {
        DMA_ISA  = 2'h0,
        DMA_PCPC = 2'h1,
        DMA_DIST = 2'h2,
        DMA_RSVD = 2'h3
    } dma_type_e;
    typedef enum logic [2:0] {
        DT_IDLE = 3'h1,
        DT_WAIT = 3'h2,
        DT_DONE = 3'h4
    } dt_state_e;
    typedef struct packed {
        logic [7:0]  apic_reloc_reg;
        logic [7:0]  lat_ctrl_reg;
        logic [15:0] dma_type_reg;
        logic [15:0] ddma_lo_reg;
        logic [15:0] ddma_hi_reg;
        logic [31:0] gen_cfg_reg;
        logic        strap_meta_reg;
        logic        strap_sync_reg;
        dt_state_e   dt_state_reg;
        logic [15:0] discard_cnt_reg;
        logic        serr_reg;
        logic [31:0] rdata_reg;
    } state_s;
endpackage

// ### design/isa_bridge_config_regs.sv
`timescale 1ns/1ps
`include "isa_bridge_consts.svh"
module isa_bridge_config_regs
    import isa_bridge_pkg::*;
#(
    parameter int DISCARD_LIMIT = `DISCARD_CYCLES
) (
    input  wire logic        clk_sys_in,
    input  wire logic        arst_n_in,
    input  wire logic        clk_en_in,
    input  wire logic        cfg_wr_in,
    input  wire logic        cfg_rd_in,
    input  wire logic [7:0]  cfg_addr_in,
    input  wire logic [3:0]  cfg_be_in,
    input  wire logic [31:0] cfg_wdata_in,
    output logic      [31:0] cfg_rdata_out,
    input  wire logic        strap_pin_two_in,
    input  wire logic [31:0] mem_addr_in,
    input  wire logic [15:0] io_addr_in,
    input  wire logic        io_cycle_in,
    input  wire logic        mem_cycle_in,
    output logic             ioapic_chip_select_n_out,
    output logic             ddma_claim_lo_out,
    output logic             ddma_claim_hi_out,
    output logic [1:0]       ddma_slot_out,
    output logic             pnp_forward_out,
    input  wire logic [7:0]  isa_dreq_in,
    input  wire logic [7:0]  pcpci_req_in,
    output logic [7:0]       isa_dreq_gated_out,
    output logic [7:0]       pcpci_req_gated_out,
    output logic [31:0]      pin_select_out,
    output logic             ide_pri_tristate_out,
    output logic             ide_sec_tristate_out,
    output logic             ide_split_drives_out,
    output logic             alt_access_out,
    output logic             positive_decode_out,
    input  wire logic        serial_interrupt_line_enable_in,
    output logic             serial_interrupt_line_active_out,
    input  wire logic [7:0]  type_f_ctrl_in,
    output logic             passive_release_out,
    input  wire logic        pci_start_in,
    input  wire logic        pci_retry_match_in,
    input  wire logic        isa_done_in,
    output logic             pci_retry_out,
    output logic             dt_pending_out,
    output logic             system_error_n_out
);
    ////////////////////////////////////////////////////////////////////////
    state_s st_reg;
    state_s st_next;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be,
                                          input logic [31:0] mask);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    function automatic logic ddma_hit(input logic [15:0] bp, input logic [15:0] a);
        return bp[15:6] == a[15:6];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // byte-wide dword view; offsets within a dword are dropped, byte enables select lanes
    logic [7:0]  dw_addr;
    logic [31:0] gen_view;
    assign dw_addr  = {cfg_addr_in[7:2], 2'h0};
    assign gen_view = {st_reg.gen_cfg_reg[31:4], st_reg.strap_sync_reg,
                       st_reg.gen_cfg_reg[2:0]};

    always_comb begin
        logic [31:0] w;
        w = 32'h0;
        st_next = st_reg;
        // strap sampled through two flops, reflected live
        st_next.strap_meta_reg = strap_pin_two_in;
        st_next.strap_sync_reg = st_reg.strap_meta_reg;
        if (cfg_wr_in) begin
            case (dw_addr)
                `OFF_APIC_RELOC: begin
                    w = merge({8'h0, st_reg.lat_ctrl_reg, 8'h0, st_reg.apic_reloc_reg},
                              cfg_wdata_in, cfg_be_in,
                              {8'h0, `LAT_CTRL_MASK, 8'h0, `APIC_RELOC_MASK});
                    st_next.apic_reloc_reg = w[7:0] & `APIC_RELOC_MASK;
                    st_next.lat_ctrl_reg   = w[23:16] & `LAT_CTRL_MASK;
                end
                `OFF_DMA_TYPE: begin
                    w = merge({st_reg.ddma_lo_reg, st_reg.dma_type_reg}, cfg_wdata_in,
                              cfg_be_in, {`DDMA_BP_MASK, `DMA_TYPE_MASK});
                    st_next.dma_type_reg = w[15:0];
                    st_next.ddma_lo_reg  = w[31:16];
                end
                `OFF_DDMA_HI: begin
                    w = merge({16'h0, st_reg.ddma_hi_reg}, cfg_wdata_in, cfg_be_in,
                              {16'h0, `DDMA_BP_MASK});
                    st_next.ddma_hi_reg = w[15:0];
                end
                `OFF_GEN_CFG: begin
                    w = merge(st_reg.gen_cfg_reg, cfg_wdata_in, cfg_be_in,
                              `GEN_CFG_MASK);
                    st_next.gen_cfg_reg = w;
                end
                default: begin
                    w = 32'h0;
                end
            endcase
        end
        if (cfg_rd_in) begin
            case (dw_addr)
                `OFF_APIC_RELOC: st_next.rdata_reg =
                    {8'h0, st_reg.lat_ctrl_reg, 8'h0, st_reg.apic_reloc_reg};
                `OFF_DMA_TYPE:   st_next.rdata_reg =
                    {st_reg.ddma_lo_reg, st_reg.dma_type_reg};
                `OFF_DDMA_HI:    st_next.rdata_reg = {16'h0, st_reg.ddma_hi_reg};
                `OFF_GEN_CFG:    st_next.rdata_reg = gen_view;
                default:         st_next.rdata_reg = 32'h0;
            endcase
        end
        // delayed transaction: retry now, finish on isa, discard if stale
        st_next.serr_reg = 1'b0;
        case (st_reg.dt_state_reg)
            DT_IDLE: begin
                st_next.discard_cnt_reg = 16'h0;
                if (pci_start_in && st_reg.lat_ctrl_reg[`LAT_DT_EN_BIT]) begin
                    st_next.dt_state_reg = DT_WAIT;
                end
            end
            DT_WAIT: begin
                st_next.discard_cnt_reg = st_reg.discard_cnt_reg + 16'h1;
                if (isa_done_in) begin
                    st_next.dt_state_reg = DT_DONE;
                    st_next.discard_cnt_reg = 16'h0;
                end
            end
            DT_DONE: begin
                st_next.discard_cnt_reg = st_reg.discard_cnt_reg + 16'h1;
                if (pci_retry_match_in) begin
                    st_next.dt_state_reg = DT_IDLE;
                end else if (32'(st_reg.discard_cnt_reg) >= DISCARD_LIMIT - 1) begin
                    st_next.dt_state_reg = DT_IDLE;
                    st_next.serr_reg = st_reg.lat_ctrl_reg[`LAT_SERR_BIT];
                end
            end
            default: begin
                st_next.dt_state_reg = DT_IDLE;
            end
        endcase
        if (!clk_en_in) begin
            st_next = st_reg;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_reg <= '{dt_state_reg: DT_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apic window at FEC0_xy00/xy10, 1k granularity
    logic apic_match;
    always_comb begin
        apic_match = mem_cycle_in && mem_addr_in[31:16] == `APIC_TOP
            && mem_addr_in[15:13] == st_reg.apic_reloc_reg[5:3]
            && mem_addr_in[11:10] == st_reg.apic_reloc_reg[1:0]
            && mem_addr_in[9:5] == 5'h0;
        if (!st_reg.apic_reloc_reg[6]) begin
            apic_match = apic_match && mem_addr_in[12] == st_reg.apic_reloc_reg[2];
        end
    end
    assign ioapic_chip_select_n_out = !apic_match;

    // distributed dma decode; channel 4 slot stays closed
    logic hit_lo;
    logic hit_hi;
    assign hit_lo = io_cycle_in && ddma_hit(st_reg.ddma_lo_reg, io_addr_in);
    assign hit_hi = io_cycle_in && ddma_hit(st_reg.ddma_hi_reg, io_addr_in)
                    && io_addr_in[5:4] != 2'h0;
    assign ddma_claim_lo_out = hit_lo;
    assign ddma_claim_hi_out = hit_hi;
    assign ddma_slot_out     = io_addr_in[5:4];

    assign pnp_forward_out = io_cycle_in && st_reg.gen_cfg_reg[`GEN_PNP_BIT]
        && (io_addr_in == `PNP_ADDR_A || io_addr_in == `PNP_ADDR_B);

    always_comb begin
        for (int c = 0; c < 8; c++) begin
            isa_dreq_gated_out[c]  = isa_dreq_in[c];
            pcpci_req_gated_out[c] = pcpci_req_in[c];
            if (c != 4 && st_reg.dma_type_reg[c*2 +: 2] == DMA_DIST) begin
                isa_dreq_gated_out[c]  = 1'b0;
                pcpci_req_gated_out[c] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign pin_select_out       = st_reg.gen_cfg_reg;
    assign ide_pri_tristate_out = st_reg.gen_cfg_reg[`GEN_PRI_TRI_BIT];
    assign ide_sec_tristate_out = st_reg.gen_cfg_reg[`GEN_SEC_TRI_BIT];
    assign ide_split_drives_out = st_reg.gen_cfg_reg[`GEN_SPLIT_BIT];
    assign alt_access_out       = st_reg.gen_cfg_reg[`GEN_ALT_BIT];
    assign positive_decode_out  = st_reg.gen_cfg_reg[`GEN_DECODE_BIT];
    assign serial_interrupt_line_active_out    = serial_interrupt_line_enable_in
                                  && st_reg.gen_cfg_reg[`GEN_SIRQ_BIT];
    assign passive_release_out  = type_f_ctrl_in[`PASSIVE_BIT];
    // retry answered in the request cycle itself, well inside 16 clocks
    assign pci_retry_out = pci_start_in && st_reg.lat_ctrl_reg[`LAT_DT_EN_BIT]
                           && st_reg.dt_state_reg != DT_DONE;
    assign dt_pending_out     = st_reg.dt_state_reg != DT_IDLE;
    assign system_error_n_out = !st_reg.serr_reg;
    assign cfg_rdata_out      = st_reg.rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    apic_single_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !st_reg.apic_reloc_reg[6] && mem_addr_in[12] != st_reg.apic_reloc_reg[2]
        |-> ioapic_chip_select_n_out)
        else $error("apic selected outside single window");
    apic_double_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        st_reg.apic_reloc_reg[6] && mem_cycle_in && mem_addr_in[31:16] == `APIC_TOP
        && mem_addr_in[15:13] == st_reg.apic_reloc_reg[5:3]
        && mem_addr_in[11:5] == {st_reg.apic_reloc_reg[1:0], 5'h0}
        |-> !ioapic_chip_select_n_out)
        else $error("apic window missed with bit12 ignored");
    discard_serr_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !system_error_n_out |-> $past(st_reg.lat_ctrl_reg[3])
        && $past(st_reg.dt_state_reg) == DT_DONE)
        else $error("system error without enabled discard");
    dt_disabled_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !st_reg.lat_ctrl_reg[0] |-> !pci_retry_out)
        else $error("retry with delayed transactions off");
    retry_prompt_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        pci_start_in && st_reg.lat_ctrl_reg[0] && st_reg.dt_state_reg == DT_IDLE
        |-> pci_retry_out)
        else $error("no prompt retry");
    dist_ignore_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        st_reg.dma_type_reg[1:0] == 2'h2 |-> !isa_dreq_gated_out[0]
        && !pcpci_req_gated_out[0])
        else $error("distributed channel took a request");
    bp_low_zero_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        st_reg.ddma_lo_reg[5:0] == 6'h0 && st_reg.ddma_hi_reg[5:0] == 6'h0)
        else $error("base pointer low bits not zero");
    slot_four_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        io_addr_in[5:4] == 2'h0 |-> !ddma_claim_hi_out)
        else $error("channel four slot claimed");
    strap_follow_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in [*3] |-> gen_view[3] == $past(strap_pin_two_in, 2))
        else $error("strap status not following pin");
    serial_interrupt_line_gate_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        serial_interrupt_line_active_out |-> st_reg.gen_cfg_reg[16])
        else $error("serial irq active without pin select");

    ////////////////////////////////////////////////////////////////////////
    // enable low must hold every bit of state, sync flops included
    freeze_hold_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !clk_en_in |=> $stable(st_reg))
        else $error("state moved while clock enable low");
    serial_interrupt_line_on_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        serial_interrupt_line_enable_in && st_reg.gen_cfg_reg[16] |-> serial_interrupt_line_active_out)
        else $error("serial irq not active when selected");
    pnp_decode_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        io_cycle_in && st_reg.gen_cfg_reg[6] && io_addr_in == 16'h0A79
        |-> pnp_forward_out)
        else $error("pnp address not forwarded");
    pnp_off_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !st_reg.gen_cfg_reg[6] |-> !pnp_forward_out)
        else $error("pnp forwarded while disabled");
    ide_tristate_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        ide_pri_tristate_out == st_reg.gen_cfg_reg[11]
        && ide_sec_tristate_out == st_reg.gen_cfg_reg[12])
        else $error("ide tri-state not following control");
    ide_split_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        ide_split_drives_out == st_reg.gen_cfg_reg[4])
        else $error("ide split not following control");
    alt_access_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        alt_access_out == st_reg.gen_cfg_reg[5])
        else $error("alternate access not following control");
    decode_sel_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        positive_decode_out == st_reg.gen_cfg_reg[1])
        else $error("decode select not following control");
    pin_select_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        pin_select_out == st_reg.gen_cfg_reg)
        else $error("pin select differs from register");
    // reserved and read-only positions never hold a written one
    reserved_zero_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        st_reg.gen_cfg_reg[26] == 1'b0 && st_reg.gen_cfg_reg[13] == 1'b0
        && st_reg.gen_cfg_reg[7] == 1'b0 && st_reg.lat_ctrl_reg[7:4] == 4'h0
        && st_reg.apic_reloc_reg[7] == 1'b0 && st_reg.dma_type_reg[9:8] == 2'h0)
        else $error("reserved bit held a one");
    latency_inert_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        st_reg.lat_ctrl_reg[2:1] == 2'h0)
        else $error("unimplemented latency bits set");
    strap_ro_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        st_reg.gen_cfg_reg[3] == 1'b0)
        else $error("strap status bit was written");
    passive_src_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        passive_release_out == type_f_ctrl_in[7])
        else $error("passive release from wrong source");
    serr_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !system_error_n_out |=> system_error_n_out)
        else $error("system error longer than one cycle");
    discard_bound_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        st_reg.dt_state_reg == DT_DONE |-> 32'(st_reg.discard_cnt_reg) < DISCARD_LIMIT)
        else $error("discard timer ran past its limit");
    dist_ch5_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        st_reg.dma_type_reg[11:10] == 2'h2 |-> !isa_dreq_gated_out[5]
        && !pcpci_req_gated_out[5])
        else $error("distributed channel five took a request");
    normal_pass_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        st_reg.dma_type_reg[1:0] != 2'h2 |-> isa_dreq_gated_out[0] == isa_dreq_in[0])
        else $error("non-distributed channel request dropped");
    ddma_lo_claim_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        io_cycle_in && io_addr_in[15:6] == st_reg.ddma_lo_reg[15:6] |-> ddma_claim_lo_out)
        else $error("low pointer window not claimed");
    ddma_hi_claim_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        io_cycle_in && io_addr_in[15:6] == st_reg.ddma_hi_reg[15:6]
        && io_addr_in[5:4] != 2'h0 |-> ddma_claim_hi_out)
        else $error("high pointer window not claimed");
    apic_idle_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !mem_cycle_in |-> ioapic_chip_select_n_out)
        else $error("apic selected without memory cycle");
endmodule

// ### sim/pci_host_model.sv
`timescale 1ns/1ps
module pci_host_model (
    input  wire logic        clk_in,
    input  wire logic [31:0] rdata_in,
    output logic             wr_out,
    output logic             rd_out,
    output logic [7:0]       addr_out,
    output logic [3:0]       be_out,
    output logic [31:0]      wdata_out
);
    initial begin
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        addr_out  = 8'h00;
        be_out    = 4'h0;
        wdata_out = 32'h0;
    end
    // strobe and qualifiers held together until the sampling edge
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk_in);
        wr_out    <= 1'b1;
        addr_out  <= a;
        be_out    <= b;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        wdata_out <= ~d; // released data must not look like the last value
        #1;
    endtask
    task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        rd_out   <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1;
        d = rdata_in;
    endtask
endmodule

// ### sim/isa_bridge_config_regs_bench.sv
`timescale 1ns/1ps
module isa_bridge_config_regs_bench;
    typedef struct packed {
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
        logic [31:0] exp;
    } row_s;
    logic        clk_sys_in = 1'b0;
    logic        arst_n_in  = 1'b0;
    logic        cfg_wr, cfg_rd, cs_n, claim_lo, claim_hi, pnp, sirq_act, passive;
    logic        pri_tri, sec_tri, split, alt, pos_dec, retry, pend, serr_n;
    logic [1:0]  slot;
    logic [3:0]  cfg_be;
    logic [7:0]  cfg_addr, dreq_g, preq_g;
    logic [31:0] cfg_wdata, cfg_rdata, rd_val, pin_sel;
    logic [31:0] mem_addr   = 32'h0;
    logic [15:0] io_addr    = 16'h0;
    logic [7:0]  dreq       = 8'h00;
    logic [7:0]  preq       = 8'h00;
    logic [7:0]  tfc        = 8'h00;
    logic        strap      = 1'b0; // board pull-down holds it low
    logic        sirq_en    = 1'b0;
    logic        start      = 1'b0;
    logic        rmatch     = 1'b0;
    logic        done       = 1'b0;
    logic        clk_en     = 1'b1;
    int          fail_count = 0;
    int          compares   = 0;
    row_s        rows [7]   = '{
        '{8'h80, 4'h1, 32'hFFFF_FFFF, 32'h0000_007F},
        '{8'h82, 4'h4, 32'hFFFF_FFFF, 32'h0009_007F},
        '{8'h90, 4'hF, 32'hFFFF_FFFF, 32'hFFC0_FCFF},
        '{8'h94, 4'hF, 32'hFFFF_FFFF, 32'h0000_FFC0},
        '{8'hB0, 4'hF, 32'hFFFF_FFFF, 32'hFBFF_DF72},
        '{8'hB0, 4'h1, 32'h0000_0000, 32'hFBFF_DF00},
        '{8'h40, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}
    };

    isa_bridge_config_regs #(.DISCARD_LIMIT(16)) dut_u (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en),
        .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd), .cfg_addr_in(cfg_addr), .cfg_be_in(cfg_be),
        .cfg_wdata_in(cfg_wdata), .cfg_rdata_out(cfg_rdata), .strap_pin_two_in(strap),
        .mem_addr_in(mem_addr), .io_addr_in(io_addr), .io_cycle_in(1'b1),
        .mem_cycle_in(1'b1), .ioapic_chip_select_n_out(cs_n), .ddma_claim_lo_out(claim_lo),
        .ddma_claim_hi_out(claim_hi), .ddma_slot_out(slot), .pnp_forward_out(pnp),
        .isa_dreq_in(dreq), .pcpci_req_in(preq), .isa_dreq_gated_out(dreq_g),
        .pcpci_req_gated_out(preq_g), .pin_select_out(pin_sel),
        .ide_pri_tristate_out(pri_tri), .ide_sec_tristate_out(sec_tri),
        .ide_split_drives_out(split), .alt_access_out(alt), .positive_decode_out(pos_dec),
        .serial_interrupt_line_enable_in(sirq_en), .serial_interrupt_line_active_out(sirq_act), .type_f_ctrl_in(tfc),
        .passive_release_out(passive), .pci_start_in(start), .pci_retry_match_in(rmatch),
        .isa_done_in(done), .pci_retry_out(retry), .dt_pending_out(pend),
        .system_error_n_out(serr_n)
    );
    pci_host_model host_u (
        .clk_in(clk_sys_in), .rdata_in(cfg_rdata), .wr_out(cfg_wr), .rd_out(cfg_rd),
        .addr_out(cfg_addr), .be_out(cfg_be), .wdata_out(cfg_wdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // decode outputs are combinational: look one step after the edge
    task automatic dec_chk(input logic [31:0] m, input logic [15:0] a, input logic [5:0] e);
        @(posedge clk_sys_in);
        mem_addr <= m;
        io_addr  <= a;
        #1;
        chk({26'h0, cs_n, claim_lo, claim_hi, slot, pnp}, {26'h0, e});
    endtask
    // e = {retry on start, system error seen}; pending must clear by the end
    task automatic dt_run(input logic [1:0] e);
        logic [1:0] seen;
        @(posedge clk_sys_in);
        start <= 1'b1;
        #1;
        seen = {retry, 1'b0};
        @(posedge clk_sys_in);
        start <= 1'b0;
        done  <= 1'b1;
        @(posedge clk_sys_in);
        done <= 1'b0;
        repeat (40) begin
            @(posedge clk_sys_in);
            #1;
            seen[0] = seen[0] | ~serr_n;
        end
        chk({29'h0, pend, seen}, {30'h0, e});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #20us;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            host_u.cfg_read(rows[i].addr, rd_val);
            chk(rd_val, 32'h0);
        end
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            host_u.cfg_write(rows[i].addr, rows[i].be, rows[i].wdata);
            host_u.cfg_read(rows[i].addr, rd_val);
            chk(rd_val, rows[i].exp);
        end
        chk(pin_sel, 32'hFBFF_DF00);
        chk({27'h0, sec_tri, pri_tri, split, alt, pos_dec}, 32'h18);
        host_u.cfg_write(8'hB0, 4'h3, 32'h0000_0872);
        chk({27'h0, sec_tri, pri_tri, split, alt, pos_dec}, 32'h0F);
        $display("test registers done");
        sirq_en <= 1'b1;
        dec_chk(32'h0, 16'h0279, 6'b100111);
        dec_chk(32'h0, 16'h0A79, 6'b100111);
        dec_chk(32'h0, 16'h027A, 6'b100110);
        chk({31'h0, sirq_act}, 32'h1);
        host_u.cfg_write(8'hB0, 4'h5, 32'h0000_0000);
        chk({31'h0, sirq_act}, 32'h0);
        dec_chk(32'h0, 16'h0279, 6'b100110);
        host_u.cfg_write(8'h90, 4'hF, 32'h1240_C806);
        host_u.cfg_write(8'h94, 4'h3, 32'h0000_3400);
        dec_chk(32'h0, 16'h1250, 6'b110010);
        dec_chk(32'h0, 16'h1280, 6'b100000);
        dec_chk(32'h0, 16'h3430, 6'b101110);
        dec_chk(32'h0, 16'h3405, 6'b100000);
        @(posedge clk_sys_in);
        dreq <= 8'hFF;
        preq <= 8'hFF;
        #1;
        chk({16'h0, dreq_g, preq_g}, 32'hDEDE);
        $display("test io decode done");
        host_u.cfg_write(8'h80, 4'h1, 32'h0000_000E);
        dec_chk(32'hFEC0_3800, 16'h0, 6'b000000);
        dec_chk(32'hFEC0_3810, 16'h0, 6'b000000);
        dec_chk(32'hFEC0_2800, 16'h0, 6'b100000);
        dec_chk(32'hFEC0_3C00, 16'h0, 6'b100000);
        host_u.cfg_write(8'h80, 4'h1, 32'h0000_004E);
        dec_chk(32'hFEC0_2810, 16'h0, 6'b000000);
        dec_chk(32'hFEC0_3400, 16'h0, 6'b100000);
        @(posedge clk_sys_in);
        tfc   <= 8'h80;
        strap <= 1'b1;
        #1;
        chk({31'h0, passive}, 32'h1);
        repeat (3) @(posedge clk_sys_in);
        host_u.cfg_read(8'hB0, rd_val);
        chk({31'h0, rd_val[3]}, 32'h1);
        $display("test apic and strap done");
        @(posedge clk_sys_in);
        clk_en <= 1'b0;
        host_u.cfg_write(8'h82, 4'h4, 32'h0000_0000);
        @(posedge clk_sys_in);
        clk_en <= 1'b1;
        host_u.cfg_read(8'h80, rd_val);
        chk(rd_val, 32'h0009_004E);
        $display("test clock enable done");
        dt_run(2'b11);
        host_u.cfg_write(8'h82, 4'h4, 32'h0001_0000);
        dt_run(2'b10);
        host_u.cfg_write(8'h82, 4'h4, 32'h0000_0000);
        dt_run(2'b00);
        $display("test delayed transaction done");
        end_sim();
    end
endmodule
